// file: rtl/lsr_request_decoder.sv
// serial service request decoder on the link request line
//
// Notes on behaviour
// RULE_01: link sends each request serially, one bit per interface clock sample.
// RULE_02: every request starts with a 1 bit and ends with a 0 bit.
// RULE_03: bit 0 goes first and is most significant; bits 1-3 give the type.
// RULE_04: link keeps the request line low between requests.
// RULE_05: type 000 takes the bus at once when the interface is idle.
// RULE_06: type 001 arbitrates when idle, no subaction gap wait.
// RULE_07: type 010 arbitrates after subaction gap, ignoring fairness.
// RULE_08: type 011 arbitrates after subaction gap, obeying fairness.
// RULE_09: type 100 reads a register, returned by a later status transfer.
// RULE_10: type 101 writes data into the addressed register.
// RULE_11: type 110 controls acceleration; type 111 is reserved.
// RULE_12: bus request bits 4-6 give the packet speed.
// RULE_13: bus request is 8 bits; 7 bits allowed when bit 6 is 0.
// RULE_14: speed 000 S100, 010 S200, 100 S400; others invalid.
// RULE_15: invalid speed is arbitrated normally but sends a null packet.
// RULE_16: read request is 9 bits, address in bits 4-7.
// RULE_17: write request is 17 bits, address 4-7, data 8-15.
// RULE_18: acceleration request is 6 bits, bit 4 enables or disables.
// RULE_19: request line sampled at the 49.152 MHz interface rate.
// RULE_20: new bus requests ignored while one pends; bus reset clears them.
// RULE_21: write data lands as soon as the request has fully arrived.
// RULE_22: detect start, decode type, set length, then return to idle.
// RULE_23: reserved type is discarded with no state change.
`timescale 1ns/1ps

module lsr_request_decoder (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       link_service_request_line,
  input  wire logic       iface_idle,
  input  wire logic       subaction_gap,
  input  wire logic       bus_reset,
  input  wire logic       bus_req_done,
  input  wire logic       read_done,
  output logic            immediate_bus_request_q,
  output logic            isochronous_bus_request_q,
  output logic            priority_bus_request_q,
  output logic            fair_bus_request_q,
  output logic [2:0]      bus_req_speed_q,
  output logic            null_packet_q,
  output logic            take_bus_q,
  output logic            arbitrate_q,
  output logic            arb_fair_q,
  output logic            register_read_request_q,
  output logic [3:0]      reg_read_addr_q,
  output logic            register_write_request_q,
  output logic [3:0]      reg_write_addr_q,
  output logic [7:0]      reg_write_data_q,
  output logic            accel_enable_q,
  output logic            request_error_q
);

  function automatic logic [7:0] take_bits(input logic [16:0] f,
                                           input logic [4:0]  pos,
                                           input logic [3:0]  n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < n) begin
        r = {r[6:0], f[5'(pos + 5'(i))]};
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] stop_pos(input logic [2:0] t);
    logic [4:0] p;
    p = `LSR_POS_TLAST;
    unique case (t)
      `LSR_T_IMM, `LSR_T_ISO, `LSR_T_PRI, `LSR_T_FAIR: p = `LSR_STOP_BUS;
      `LSR_T_RD:  p = `LSR_STOP_RD;
      `LSR_T_WR:  p = `LSR_STOP_WR;
      `LSR_T_ACC: p = `LSR_STOP_ACC;
      `LSR_T_RSV: p = `LSR_POS_TLAST;
    endcase
    return p;
  endfunction

  function automatic logic spd_ok(input logic [2:0] s);
    return (s == `LSR_S100) || (s == `LSR_S200) || (s == `LSR_S400);
  endfunction

  // reset release and pin synchroniser
  logic rst_m_q;
  logic rst_s_q;
  logic rst_sync_n;
  logic line_m_q;
  logic line_s_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  assign rst_sync_n = rst_s_q;

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      line_m_q <= 1'b0;
      line_s_q <= 1'b0;
    end else begin
      line_m_q <= link_service_request_line;
      line_s_q <= line_m_q;
    end
  end

  // fractional divider: exact 49.152 MHz average sample rate from 250 MHz
  logic [18:0] acc_q;
  logic [18:0] acc_d;
  logic [18:0] acc_sum;
  logic        tick_q;
  logic        tick_d;

  always_comb begin
    acc_sum = acc_q + `LSR_IFACE_KHZ;
    acc_d   = acc_sum;
    tick_d  = 1'b0;
    if (acc_sum >= `LSR_CORE_KHZ) begin // RULE_19
      acc_d  = acc_sum - `LSR_CORE_KHZ;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      acc_q  <= `LSR_ACC_ZERO;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  // stream decoder
  lsr_pkg::lsr_state_t state_q;
  lsr_pkg::lsr_state_t state_d;
  logic [4:0]          cnt_q;
  logic [4:0]          cnt_d;
  logic [16:0]         bits_q;
  logic [16:0]         bits_d;
  logic [16:0]         cur;
  logic [2:0]          cur_type;
  logic                exec;
  logic                bad;

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    bits_d   = bits_q;
    cur      = bits_q;
    cur[cnt_q] = line_s_q;
    cur_type = take_bits(cur, `LSR_POS_TYPE, `LSR_W_TYPE)[2:0]; // RULE_03
    exec     = 1'b0;
    bad      = 1'b0;
    if (tick_q) begin // RULE_01 RULE_19
      unique case (state_q)
        lsr_pkg::LSR_IDLE: begin
          if (line_s_q) begin // RULE_02 RULE_04 RULE_22
            state_d = lsr_pkg::LSR_BODY;
            cnt_d   = `LSR_CNT_ONE;
            bits_d  = `LSR_FRAME_ONE;
          end
        end
        lsr_pkg::LSR_BODY: begin
          bits_d = cur;
          cnt_d  = cnt_q + `LSR_CNT_ONE;
          if (cnt_q == `LSR_POS_TLAST && cur_type == `LSR_T_RSV) begin
            state_d = lsr_pkg::LSR_IDLE; // RULE_11 RULE_23
            bad     = 1'b1;
          end else if (cnt_q == stop_pos(cur_type)) begin // RULE_16 RULE_17 RULE_18
            state_d = lsr_pkg::LSR_IDLE; // RULE_22
            exec    = !line_s_q; // RULE_02
            bad     = line_s_q;
          end else if (!cur_type[2] && cnt_q == `LSR_POS_OPT && !line_s_q) begin
            // short form done; a stop bit may still follow
            state_d = lsr_pkg::LSR_OPT; // RULE_13
            exec    = 1'b1;
          end
        end
        lsr_pkg::LSR_OPT: begin
          // a 1 here can only be the next start bit
          if (line_s_q) begin // RULE_13
            state_d = lsr_pkg::LSR_BODY;
            cnt_d   = `LSR_CNT_ONE;
            bits_d  = `LSR_FRAME_ONE;
          end else begin
            state_d = lsr_pkg::LSR_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= lsr_pkg::LSR_IDLE;
      cnt_q   <= `LSR_POS_START;
      bits_q  <= `LSR_FRAME_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      bits_q  <= bits_d;
    end
  end

  // request service
  logic       any_pend;
  logic       bus_set;
  logic [2:0] cur_speed;
  logic       imm_d;
  logic       iso_d;
  logic       pri_d;
  logic       fair_d;
  logic [2:0] speed_d;
  logic       null_d;
  logic       take_d;
  logic       arb_d;
  logic       arb_fair_d;
  logic       rd_d;
  logic [3:0] rd_addr_d;
  logic       wr_d;
  logic [3:0] wr_addr_d;
  logic [7:0] wr_data_d;
  logic       accel_d;

  always_comb begin
    any_pend  = immediate_bus_request_q | isochronous_bus_request_q |
                priority_bus_request_q | fair_bus_request_q;
    cur_speed = take_bits(cur, `LSR_POS_FIELD, `LSR_W_SPEED)[2:0]; // RULE_12
    bus_set   = exec && !cur_type[2] && !any_pend; // RULE_20
    imm_d     = immediate_bus_request_q;
    iso_d     = isochronous_bus_request_q;
    pri_d     = priority_bus_request_q;
    fair_d    = fair_bus_request_q;
    if (bus_req_done || bus_reset) begin // RULE_20
      imm_d  = 1'b0;
      iso_d  = 1'b0;
      pri_d  = 1'b0;
      fair_d = 1'b0;
    end
    speed_d = bus_req_speed_q;
    null_d  = null_packet_q;
    // an arriving request wins over a same-cycle clear when no request was already pending
    if (bus_set) begin
      imm_d   = imm_d | (cur_type == `LSR_T_IMM);
      iso_d   = iso_d | (cur_type == `LSR_T_ISO);
      pri_d   = pri_d | (cur_type == `LSR_T_PRI);
      fair_d  = fair_d | (cur_type == `LSR_T_FAIR);
      speed_d = cur_speed; // RULE_12
      null_d  = !spd_ok(cur_speed); // RULE_14 RULE_15
    end
    take_d     = immediate_bus_request_q && iface_idle; // RULE_05
    arb_d      = (isochronous_bus_request_q && iface_idle) || // RULE_06
                 ((priority_bus_request_q || fair_bus_request_q) && subaction_gap); // RULE_07
    arb_fair_d = fair_bus_request_q; // RULE_08
    rd_d       = register_read_request_q && !read_done;
    rd_addr_d  = reg_read_addr_q;
    // repeat reads are dropped until the pending one has been delivered
    if (exec && cur_type == `LSR_T_RD && !register_read_request_q) begin // RULE_09
      rd_d      = 1'b1;
      rd_addr_d = take_bits(cur, `LSR_POS_FIELD, `LSR_W_ADDR)[3:0]; // RULE_16
    end
    wr_d      = exec && cur_type == `LSR_T_WR; // RULE_10 RULE_21
    wr_addr_d = reg_write_addr_q;
    wr_data_d = reg_write_data_q;
    if (wr_d) begin
      wr_addr_d = take_bits(cur, `LSR_POS_FIELD, `LSR_W_ADDR)[3:0]; // RULE_17
      wr_data_d = take_bits(cur, `LSR_POS_DATA, `LSR_W_DATA);
    end
    accel_d = accel_enable_q;
    if (bus_reset || (bus_set && cur_type == `LSR_T_ISO)) begin
      accel_d = 1'b1;
    end
    if (exec && cur_type == `LSR_T_ACC) begin // RULE_11
      accel_d = cur[`LSR_POS_FIELD]; // RULE_18
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      immediate_bus_request_q   <= 1'b0;
      isochronous_bus_request_q <= 1'b0;
      priority_bus_request_q    <= 1'b0;
      fair_bus_request_q        <= 1'b0;
      bus_req_speed_q           <= `LSR_S100;
      null_packet_q             <= 1'b0;
      take_bus_q                <= 1'b0;
      arbitrate_q               <= 1'b0;
      arb_fair_q                <= 1'b0;
      register_read_request_q   <= 1'b0;
      reg_read_addr_q           <= 4'h0;
      register_write_request_q  <= 1'b0;
      reg_write_addr_q          <= 4'h0;
      reg_write_data_q          <= 8'h00;
      accel_enable_q            <= 1'b1;
      request_error_q           <= 1'b0;
    end else begin
      immediate_bus_request_q   <= imm_d;
      isochronous_bus_request_q <= iso_d;
      priority_bus_request_q    <= pri_d;
      fair_bus_request_q        <= fair_d;
      bus_req_speed_q           <= speed_d;
      null_packet_q             <= null_d;
      take_bus_q                <= take_d;
      arbitrate_q               <= arb_d;
      arb_fair_q                <= arb_fair_d;
      register_read_request_q   <= rd_d;
      reg_read_addr_q           <= rd_addr_d;
      register_write_request_q  <= wr_d;
      reg_write_addr_q          <= wr_addr_d;
      reg_write_data_q          <= wr_data_d;
      accel_enable_q            <= accel_d;
      request_error_q           <= bad;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_start;
    tick_q && state_q == lsr_pkg::LSR_IDLE && line_s_q;
  endsequence

  sequence s_short_end;
    tick_q && state_q == lsr_pkg::LSR_BODY && cnt_q == `LSR_POS_OPT &&
    !cur_type[2] && !line_s_q;
  endsequence

  AST_START: assert property (s_start |=> state_q == lsr_pkg::LSR_BODY && cnt_q == 5'd1) // RULE_22
    else $error("start bit not taken");

  AST_SHORT_BUS: assert property (s_short_end |=> state_q == lsr_pkg::LSR_OPT) // RULE_13
    else $error("seven bit bus request not closed");

  AST_RESERVED: assert property (tick_q && state_q == lsr_pkg::LSR_BODY && cnt_q == 5'd3
      && cur_type == `LSR_T_RSV |=> state_q == lsr_pkg::LSR_IDLE && !register_write_request_q
      && $stable(accel_enable_q) && $stable(register_read_request_q)) // RULE_23
    else $error("reserved request changed state");

  AST_WRITE: assert property (exec && cur_type == `LSR_T_WR |=> register_write_request_q
      && reg_write_data_q == $past(take_bits(cur, `LSR_POS_DATA, `LSR_W_DATA))
      ##1 !register_write_request_q) // RULE_21
    else $error("register write not issued once");

  AST_BUS_IGNORE: assert property (any_pend && exec && !cur_type[2] && !bus_req_done
      && !bus_reset |=> $stable(bus_req_speed_q) && $stable(null_packet_q)) // RULE_20
    else $error("second bus request not ignored");

  AST_BUS_RESET: assert property (bus_reset && !bus_set |=> !immediate_bus_request_q
      && !isochronous_bus_request_q && !priority_bus_request_q && !fair_bus_request_q) // RULE_20
    else $error("bus reset left a request pending");

  AST_TAKE: assert property (immediate_bus_request_q && iface_idle |=> take_bus_q) // RULE_05
    else $error("immediate request not taking bus");

  // stream bit 4 is the speed msb, so a plain part-select would read it reversed
  AST_NULL: assert property (bus_set && !spd_ok(cur_speed) |=> null_packet_q) // RULE_15
    else $error("invalid speed without null packet");

  AST_READ_HOLD: assert property (register_read_request_q && !read_done
      |=> register_read_request_q && $stable(reg_read_addr_q)) // RULE_09
    else $error("pending read address changed");

  AST_ACCEL: assert property (exec && cur_type == 3'h6 |=> accel_enable_q == $past(cur[4])) // RULE_18
    else $error("acceleration control not applied");

  AST_STOP: assert property (tick_q && state_q == lsr_pkg::LSR_BODY && cnt_q != 5'd3
      && cnt_q == stop_pos(cur_type) && line_s_q |=> request_error_q
      && state_q == lsr_pkg::LSR_IDLE) // RULE_02
    else $error("bad stop bit not flagged");

endmodule // lsr_request_decoder

// file: rtl/lsr_cfg.svh
// constants of the link service request decoder
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH

// core and interface rates in kHz, used by the sample divider
`define LSR_CORE_KHZ   19'd250000
`define LSR_IFACE_KHZ  19'd49152
`define LSR_ACC_ZERO   19'd0

// request type codes
`define LSR_T_IMM      3'h0
`define LSR_T_ISO      3'h1
`define LSR_T_PRI      3'h2
`define LSR_T_FAIR     3'h3
`define LSR_T_RD       3'h4
`define LSR_T_WR       3'h5
`define LSR_T_ACC      3'h6
`define LSR_T_RSV      3'h7

// speed codes
`define LSR_S100       3'h0
`define LSR_S200       3'h2
`define LSR_S400       3'h4

// bit positions in the stream, bit 0 first
`define LSR_POS_START  5'd0
`define LSR_POS_TYPE   5'd1
`define LSR_POS_TLAST  5'd3
`define LSR_POS_FIELD  5'd4
`define LSR_POS_OPT    5'd6
`define LSR_POS_DATA   5'd8

// stop bit positions
`define LSR_STOP_BUS   5'd7
`define LSR_STOP_RD    5'd8
`define LSR_STOP_WR    5'd16
`define LSR_STOP_ACC   5'd5

// field widths
`define LSR_W_TYPE     4'd3
`define LSR_W_SPEED    4'd3
`define LSR_W_ADDR     4'd4
`define LSR_W_DATA     4'd8

`define LSR_FRAME_ZERO 17'h00000
`define LSR_FRAME_ONE  17'h00001
`define LSR_CNT_ONE    5'd1

`endif

// file: rtl/lsr_pkg.sv
// types of the link service request decoder
package lsr_pkg;
  `include "lsr_cfg.svh"

  typedef enum logic [2:0] {
    LSR_IDLE = 3'b001,
    LSR_BODY = 3'b010,
    LSR_OPT  = 3'b100
  } lsr_state_t;

  typedef enum logic [2:0] {
    LSR_REQ_IMM  = `LSR_T_IMM,
    LSR_REQ_ISO  = `LSR_T_ISO,
    LSR_REQ_PRI  = `LSR_T_PRI,
    LSR_REQ_FAIR = `LSR_T_FAIR,
    LSR_REQ_RD   = `LSR_T_RD,
    LSR_REQ_WR   = `LSR_T_WR,
    LSR_REQ_ACC  = `LSR_T_ACC,
    LSR_REQ_RSV  = `LSR_T_RSV
  } lsr_req_t;
endpackage

// file: sim/lsr_link_model.sv
// link controller model that drives the service request line
`timescale 1ns/1ps

module lsr_link_model (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      link_service_request_line
);
  logic [1:0]  rs_q;
  logic [18:0] acc_q;
  logic        tick_q;

  initial link_service_request_line = 1'b0;

  // mirrors the decoder's sample divider so each bit change falls between two of its samples
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_q   <= 2'h0;
      acc_q  <= 19'h0;
      tick_q <= 1'b0;
    end else begin
      rs_q   <= {rs_q[0], 1'b1};
      tick_q <= rs_q[1] && (acc_q + 19'd49152 >= 19'd250000);
      if (!rs_q[1])
        acc_q <= 19'h0;
      else if (acc_q + 19'd49152 >= 19'd250000)
        acc_q <= acc_q + 19'd49152 - 19'd250000;
      else
        acc_q <= acc_q + 19'd49152;
    end
  end

  task automatic wait_tick();
    @(posedge core_clk);
    while (tick_q !== 1'b1) @(posedge core_clk);
    #1;
  endtask

  // stream bit 0 sits in bits[16]; gap adds idle samples, so the model answers fast or slow
  task automatic send(input logic [16:0] bits, input int len, input int gap);
    for (int i = 0; i < len; i++) begin
      wait_tick();
      link_service_request_line = bits[16-i];
    end
    for (int i = 0; i <= gap; i++) begin
      wait_tick();
      link_service_request_line = 1'b0;
    end
  endtask
endmodule // lsr_link_model

// file: sim/tb_top.sv
// self-checking bench of the link service request decoder
`timescale 1ns/1ps

`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module tb_top;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       iface_idle = 1'b0;
  logic       subaction_gap = 1'b0;
  logic       bus_reset = 1'b0;
  logic       bus_req_done = 1'b0;
  logic       read_done = 1'b0;
  logic       link_service_request_line;
  logic       immediate_bus_request_q, isochronous_bus_request_q, priority_bus_request_q;
  logic       fair_bus_request_q, null_packet_q, take_bus_q, arbitrate_q, arb_fair_q;
  logic       register_read_request_q, register_write_request_q, accel_enable_q;
  logic       request_error_q;
  logic [2:0] bus_req_speed_q;
  logic [3:0] reg_read_addr_q, reg_write_addr_q, wr_a, flags;
  logic [7:0] reg_write_data_q, wr_d;
  int         bad_count = 0, tests_run = 0, wr_seen = 0, err_seen = 0;

  assign flags = {immediate_bus_request_q, isochronous_bus_request_q,
                  priority_bus_request_q, fair_bus_request_q};

  lsr_request_decoder u_lsr_request_decoder (
    .core_clk(core_clk), .rst_n(rst_n), .link_service_request_line(link_service_request_line),
    .iface_idle(iface_idle), .subaction_gap(subaction_gap), .bus_reset(bus_reset),
    .bus_req_done(bus_req_done), .read_done(read_done),
    .immediate_bus_request_q(immediate_bus_request_q),
    .isochronous_bus_request_q(isochronous_bus_request_q),
    .priority_bus_request_q(priority_bus_request_q), .fair_bus_request_q(fair_bus_request_q),
    .bus_req_speed_q(bus_req_speed_q), .null_packet_q(null_packet_q), .take_bus_q(take_bus_q),
    .arbitrate_q(arbitrate_q), .arb_fair_q(arb_fair_q),
    .register_read_request_q(register_read_request_q), .reg_read_addr_q(reg_read_addr_q),
    .register_write_request_q(register_write_request_q), .reg_write_addr_q(reg_write_addr_q),
    .reg_write_data_q(reg_write_data_q), .accel_enable_q(accel_enable_q),
    .request_error_q(request_error_q));

  lsr_link_model u_lsr_link_model (
    .core_clk(core_clk), .rst_n(rst_n), .link_service_request_line(link_service_request_line));

  always #2 core_clk = ~core_clk;

  // pulses are counted so a pulse stuck high shows as an extra count
  always @(posedge core_clk) begin
    if (register_write_request_q === 1'b1) begin
      wr_seen++;
      wr_a = reg_write_addr_q;
      wr_d = reg_write_data_q;
    end
    if (request_error_q === 1'b1)
      err_seen++;
  end

  function automatic logic [3:0] exp_flags(input logic [2:0] t);
    return 4'h8 >> t;
  endfunction

  function automatic logic exp_null(input logic [2:0] s);
    return !(s == 3'h0 || s == 3'h2 || s == 3'h4);
  endfunction

  task automatic req(input logic [16:0] bits, input int len);
    u_lsr_link_model.send(bits, len, $urandom_range(3));
    repeat (10) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse(input int which);
    @(posedge core_clk);
    #1;
    if (which == 0) bus_req_done = 1'b1;
    else if (which == 1) bus_reset = 1'b1;
    else read_done = 1'b1;
    @(posedge core_clk);
    #1;
    bus_req_done = 1'b0;
    bus_reset = 1'b0;
    read_done = 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    $display("[ERR] watchdog expected finish seen hang");
    tally_and_finish();
  end

  initial begin
    logic [2:0] t, s;
    logic [3:0] a;
    logic [7:0] d;
    logic       om;
    int         n;
    n = $urandom(32'h0ad6);
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    `CHK("reset flags", 4'h0, flags)
    `CHK("reset accel", 1'b1, accel_enable_q)
    `CHK("reset read", 1'b0, register_read_request_q)
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      t = 3'(i % 4);
      s = (i < 8) ? i[2:0] : 3'($urandom);
      om = (s[0] == 1'b0) && ($urandom_range(1) == 1);
      req({1'b1, t, s, 1'b0, 9'h0}, om ? 7 : 8);
      `CHK("bus flags", exp_flags(t), flags)
      `CHK("bus speed", s, bus_req_speed_q)
      `CHK("null packet", exp_null(s), null_packet_q)
      iface_idle = 1'($urandom_range(1));
      subaction_gap = 1'($urandom_range(1));
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("take bus", t == 3'h0 && iface_idle, take_bus_q)
      `CHK("arbitrate", (t == 3'h1 && iface_idle) || (t >= 3'h2 && subaction_gap),
           arbitrate_q)
      `CHK("arb fair", t == 3'h3, arb_fair_q)
      req({1'b1, 3'(3 - t), 3'h4, 1'b0, 9'h0}, 8);
      `CHK("bus refused", exp_flags(t), flags)
      `CHK("speed kept", s, bus_req_speed_q)
      pulse(i % 2);
      `CHK("bus cleared", 4'h0, flags)
      $display("test bus %0d done", i);
    end
    iface_idle = 1'b0;
    a = 4'($urandom);
    req({1'b1, 3'h4, a, 1'b0, 8'h0}, 9);
    `CHK("read pend", 1'b1, register_read_request_q)
    `CHK("read addr", a, reg_read_addr_q)
    req({1'b1, 3'h4, ~a, 1'b0, 8'h0}, 9);
    `CHK("read refused", a, reg_read_addr_q)
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($urandom);
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      n = wr_seen;
      req({1'b1, 3'h5, a, d, 1'b0}, 17);
      `CHK("write count", n + 1, wr_seen)
      `CHK("write addr", a, wr_a)
      `CHK("write data", d, wr_d)
    end
    `CHK("read still", 1'b1, register_read_request_q)
    pulse(2);
    `CHK("read cleared", 1'b0, register_read_request_q)
    $display("test register done");
    for (int i = 0; i < 3; i++) begin
      req({1'b1, 3'h6, i[0], 1'b0, 11'h0}, 6);
      `CHK("accel", i[0], accel_enable_q)
    end
    pulse(1);
    `CHK("accel bus reset", 1'b1, accel_enable_q)
    `CHK("no error", 0, err_seen)
    n = err_seen;
    req({1'b1, 3'h7, 13'h0}, 4);
    `CHK("reserved error", n + 1, err_seen)
    `CHK("reserved flags", 4'h0, flags)
    `CHK("reserved read", 1'b0, register_read_request_q)
    `CHK("reserved accel", 1'b1, accel_enable_q)
    // acceleration off request whose stop bit is 1 must be dropped whole
    n = err_seen;
    req({1'b1, 3'h6, 1'b0, 1'b1, 11'h0}, 6);
    `CHK("stop error", n + 1, err_seen)
    `CHK("stop dropped", 1'b1, accel_enable_q)
    $display("test control done");
    tally_and_finish();
  end
endmodule // tb_top
